// ### src/flash_host_pkg.sv
package flash_host_pkg;
	// ==========================================
	// Bus widths and field positions
	localparam int ADDR_W    = 21;
	localparam int DATA_W    = 16;
	localparam int POLL_BIT  = 7;
	localparam int TOG1_BIT  = 6;
	localparam int TOUT_BIT  = 5;
	localparam int LOW_BYTE  = 8;
	// ==========================================
	// Command words (word mode)
	localparam logic [20:0] UNLOCK_ADDR1 = 21'h000555;
	localparam logic [20:0] UNLOCK_ADDR2 = 21'h0002AA;
	localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
	localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
	localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
	localparam logic [7:0]  CMD_AUTOSEL  = 8'h90;
	localparam logic [7:0]  CMD_ERASE    = 8'h80;
	localparam logic [7:0]  CMD_SECTOR   = 8'h30;
	localparam logic [7:0]  CMD_CHIP     = 8'h10;
	localparam logic [7:0]  CMD_RESET    = 8'hF0;
	localparam logic [7:0]  CMD_SUSPEND  = 8'hB0;
	localparam logic [7:0]  CMD_RESUME   = 8'h30;
	localparam logic [7:0]  CMD_QUERY    = 8'h98;
	localparam logic [20:0] QUERY_ADDR   = 21'h000055;
	// ==========================================
	// Host operations
	typedef enum logic [2:0] {
		OP_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_CHIP_ERASE,
		OP_AUTOSEL, OP_RESET, OP_SUSPEND, OP_RESUME
	} op_t;
	// ==========================================
	// Timing of one bus phase
	localparam int CLK_NS   = 50;
	localparam int PHASE_NS = 100;
	localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
endpackage : flash_host_pkg

// ### src/flash_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl
	import flash_host_pkg::*;
#(
	parameter int POLL_LIMIT = 65535
) (
	input  wire logic                          clk_sys,
	input  wire logic                          resetn,
	input  wire logic                          clkEn,
	input  wire logic                          cmdValid,
	input  wire flash_host_pkg::op_t           cmdOp,
	input  wire logic [flash_host_pkg::ADDR_W-1:0] cmdAddr,
	input  wire logic [flash_host_pkg::DATA_W-1:0] cmdData,
	output var  logic                          cmdReady,
	output var  logic                          doneValid,
	output var  logic                          doneFail,
	output var  logic [flash_host_pkg::DATA_W-1:0] doneData,
	output var  logic [flash_host_pkg::ADDR_W-1:0] flashAddr,
	output var  logic [flash_host_pkg::DATA_W-1:0] flashDqOut,
	output var  logic                          flashDqOe,
	input  wire logic [flash_host_pkg::DATA_W-1:0] flashDqIn,
	output var  logic                          flashCeN,
	output var  logic                          flashWeN,
	output var  logic                          flashOeN,
	input  wire logic                          readyBusyIn,
	output var  logic                          busy
);
	import flash_host_pkg::*;

	initial begin
		if (POLL_LIMIT < 2 || POLL_LIMIT > 1048575) $error("POLL_LIMIT out of range");
	end

	// ==========================================
	// Sequencing
	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_NEXT, S_DONE} st_t;
	typedef enum logic [1:0] {PH_CMD, PH_POLL1, PH_POLL2} ph_t;

	st_t         st;
	ph_t         ph;
	op_t         op;
	logic [2:0]  cyc;
	logic        isRead;
	logic [1:0]  tmr;
	logic [20:0] polls;
	logic [ADDR_W-1:0] opAddr;
	logic [DATA_W-1:0] opData;
	logic [DATA_W-1:0] firstRead;
	logic [DATA_W-1:0] lastPoll;
	logic        sawTimeout;
	logic        suspended;

	// Unlock prefix shared by all multi-cycle sequences
	function automatic logic [ADDR_W+7:0] unlockCycle(input logic [2:0] i);
		unique case (i)
			3'h0: unlockCycle = {UNLOCK_ADDR1, UNLOCK_DATA1};
			default: unlockCycle = {UNLOCK_ADDR2, UNLOCK_DATA2};
		endcase
	endfunction : unlockCycle

	// Bank/sector bits kept, command bits below bit 11 forced
	function automatic logic [ADDR_W-1:0] withBank(input logic [ADDR_W-1:0] b,
		input logic [ADDR_W-1:0] low);
		withBank = {b[ADDR_W-1:11], low[10:0]};
	endfunction : withBank

	logic [ADDR_W+7:0] cycWord;
	always_comb begin
		cycWord = unlockCycle(cyc);
		unique case (op)
			OP_PROGRAM:
				// Full unlock prefix every time: bypass mode is never entered
				if (cyc == 3'h2) cycWord = {UNLOCK_ADDR1, CMD_PROGRAM};
				else if (cyc == 3'h3) cycWord = {opAddr, opData[7:0]};
			OP_SECTOR_ERASE, OP_CHIP_ERASE:
				if (cyc == 3'h2) cycWord = {UNLOCK_ADDR1, CMD_ERASE};
				else if (cyc == 3'h3) cycWord = {UNLOCK_ADDR1, UNLOCK_DATA1};
				else if (cyc == 3'h4) cycWord = {UNLOCK_ADDR2, UNLOCK_DATA2};
				else if (cyc == 3'h5) cycWord = (op == OP_CHIP_ERASE) ?
					{UNLOCK_ADDR1, CMD_CHIP} : {withBank(opAddr, opAddr), CMD_SECTOR};
			OP_AUTOSEL:
				if (cyc == 3'h2) cycWord = {withBank(opAddr, UNLOCK_ADDR1), CMD_AUTOSEL};
				else if (cyc == 3'h3) cycWord = {opAddr, 8'h00};
			OP_RESET:   cycWord = {UNLOCK_ADDR1, CMD_RESET};
			OP_SUSPEND: cycWord = {opAddr, CMD_SUSPEND};
			OP_RESUME:  cycWord = {opAddr, CMD_RESUME};
			default:    cycWord = {opAddr, 8'h00};
		endcase
	end

	wire         pollPhase   = (ph != PH_CMD);
	wire         lastCyc     = (cyc == opCycles - 3'h1);
	wire         readCyc     = pollPhase || op == OP_READ || (op == OP_AUTOSEL && lastCyc);
	wire         progData    = (op == OP_PROGRAM && cyc == 3'h3);
	wire         toggling    = firstRead[TOG1_BIT] != lastPoll[TOG1_BIT];
	wire         pollDone    = !toggling && (op != OP_PROGRAM ||
		lastPoll[POLL_BIT] == opData[POLL_BIT]);
	wire         cmdOk       = !(op == OP_SUSPEND && !busy) && !(op == OP_RESUME && !suspended);
	wire [2:0]   opCycles    = (op == OP_PROGRAM) ? 3'h4 :
		(op == OP_SECTOR_ERASE || op == OP_CHIP_ERASE) ? 3'h6 :
		(op == OP_AUTOSEL) ? 3'h4 : 3'h1;
	wire         needsPoll   = (op == OP_PROGRAM || op == OP_SECTOR_ERASE || op == OP_CHIP_ERASE);

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			st <= S_IDLE;
			ph <= PH_CMD;
			op <= OP_READ;
			cyc <= 3'h0;
			isRead <= 1'b0;
			tmr <= 2'h0;
			polls <= 21'h0;
			opAddr <= '0;
			opData <= '0;
			firstRead <= '0;
			lastPoll <= '0;
			sawTimeout <= 1'b0;
			suspended <= 1'b0;
			cmdReady <= 1'b0;
			doneValid <= 1'b0;
			doneFail <= 1'b0;
			doneData <= '0;
			flashAddr <= '0;
			flashDqOut <= '0;
			flashDqOe <= 1'b0;
			flashCeN <= 1'b1;
			flashWeN <= 1'b1;
			flashOeN <= 1'b1;
			busy <= 1'b0;
		end else if (clkEn) begin
			doneValid <= 1'b0;
			busy <= !readyBusyIn;
			unique case (st)
				S_IDLE: begin
					cmdReady <= 1'b1;
					if (cmdValid && cmdReady) begin
						cmdReady <= 1'b0;
						op <= cmdOp;
						opAddr <= cmdAddr;
						opData <= cmdData;
						cyc <= 3'h0;
						ph <= PH_CMD;
						polls <= 21'h0;
						sawTimeout <= 1'b0;
						st <= S_NEXT;
					end
				end
				S_NEXT: begin
					if (!pollPhase && !cmdOk) begin
						doneFail <= 1'b1;
						st <= S_DONE;
					end else begin
						// Address settles a full phase before either strobe falls
						isRead <= readCyc;
						flashAddr <= pollPhase ? opAddr : cycWord[ADDR_W+7:8];
						flashDqOut <= progData ? opData :
							{{LOW_BYTE{1'b0}}, cycWord[7:0]};
						flashDqOe <= !readCyc;
						flashCeN <= 1'b0;
						tmr <= 2'(PHASE_CYC);
						st <= S_SETUP;
					end
				end
				S_SETUP: if (tmr == 2'h1) begin
					flashWeN <= isRead;
					flashOeN <= !isRead;
					tmr <= 2'(PHASE_CYC);
					st <= S_STROBE;
				end else tmr <= tmr - 2'h1;
				S_STROBE: if (tmr == 2'h1) begin
					flashWeN <= 1'b1;
					flashOeN <= 1'b1;
					if (ph == PH_POLL1) firstRead <= flashDqIn;
					if (ph == PH_POLL2) lastPoll <= flashDqIn;
					if (isRead && !pollPhase) doneData <= flashDqIn;
					tmr <= 2'(PHASE_CYC);
					st <= S_HOLD;
				end else tmr <= tmr - 2'h1;
				S_HOLD: if (tmr == 2'h1) begin
					// Data held a phase after write strobe rises
					flashCeN <= 1'b1;
					flashDqOe <= 1'b0;
					st <= S_NEXT;
					if (ph == PH_CMD && !lastCyc) cyc <= cyc + 3'h1;
					else if (ph == PH_CMD) begin
						if (op == OP_SUSPEND) suspended <= 1'b1;
						if (op == OP_RESUME || op == OP_RESET) suspended <= 1'b0;
						if (needsPoll) ph <= PH_POLL1;
						else st <= S_DONE;
					end else if (ph == PH_POLL1) ph <= PH_POLL2;
					else if (!toggling) begin
						// Toggle stopped: a wrong polling bit means nothing was written
						doneFail <= !pollDone;
						st <= S_DONE;
					end else if (sawTimeout || polls == 21'(POLL_LIMIT)) begin
						// Timeout seen last time or POLL_LIMIT+1 rounds polled, and still toggling: give up
						doneFail <= 1'b1;
						st <= S_DONE;
					end else begin
						// Timeout flag only noted here, so one more round rechecks the toggle
						sawTimeout <= lastPoll[TOUT_BIT];
						polls <= polls + 21'h1;
						ph <= PH_POLL1;
					end
				end else tmr <= tmr - 2'h1;
				S_DONE: begin
					doneValid <= 1'b1;
					st <= S_IDLE;
				end
				default: st <= S_IDLE;
			endcase
			if (st == S_IDLE && cmdValid && cmdReady) doneFail <= 1'b0;
		end
	end

	// ==========================================
	// Checks
	chk_strobes_exclusive: assert property (@(posedge clk_sys) disable iff (!resetn)
		!(!flashWeN && !flashOeN)) else $error("both strobes low");
	chk_addr_stable: assert property (@(posedge clk_sys) disable iff (!resetn)
		(!flashWeN && $past(!flashWeN)) |-> $stable(flashAddr)) else $error("address moved");
	chk_data_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(flashWeN) |-> flashDqOe && $stable(flashDqOut)) else $error("data dropped");
	chk_upper_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
		(!flashWeN && !progData) |-> flashDqOut[15:8] == 8'h00) else $error("upper byte");
	chk_write_oe: assert property (@(posedge clk_sys) disable iff (!resetn)
		!flashWeN |-> flashDqOe) else $error("write without drive");
	chk_read_released: assert property (@(posedge clk_sys) disable iff (!resetn)
		!flashOeN |-> !flashDqOe) else $error("read while driving");
	chk_busy_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
		$past(clkEn) |-> busy == !$past(readyBusyIn)) else $error("busy lags pin");
endmodule : flash_host_ctrl
`default_nettype wire

// ### test/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Edge-driven flash, one bank; status lasts three reads, or never ends while stuck
module flash_dev_model
	import flash_host_pkg::*;
#(
	parameter logic [8:0] PROT_SECTOR = 9'h1F0
) (
	input  wire logic [20:0] addr,
	input  wire logic [15:0] dqHost,
	input  wire logic        ceN,
	input  wire logic        weN,
	input  wire logic        oeN,
	input  wire logic        stuck,
	output var  logic [15:0] dq,
	output var  logic        rdyBsy,
	output var  logic        upperBad
);
	logic [15:0] mem [16];
	logic [15:0] last, pv;
	logic [20:0] aLat, pa;
	logic        tog, auto, erArm, er, wipe;
	int          step, busyRd;
	initial begin
		{dq, last, pv, tog, auto, erArm, er, wipe, upperBad} = '0;
		step = 0;
		busyRd = 0;
		foreach (mem[i]) mem[i] = 16'h0000;
	end
	assign rdyBsy = (busyRd == 0);
	always @(negedge (weN | ceN)) aLat = addr;
	always @(posedge (weN | ceN)) begin
		if (step != 4 && dqHost[15:8] !== 8'h00) upperBad = 1'b1;
		if (step == 4) begin
			pa = aLat;
			pv = dqHost;
			er = 1'b0;
			busyRd = stuck ? 999 : 3;
			step = 0;
		end else if (dqHost[7:0] == CMD_RESET) begin
			busyRd = 0;
			step = 0;
			auto = 1'b0;
		end else if (step == 0 && aLat[10:0] == 11'h555 && dqHost[7:0] == 8'hAA) step = 1;
		else if (step == 1 && aLat[10:0] == 11'h2AA && dqHost[7:0] == 8'h55) step = 2;
		else if (step == 2) begin
			step = (dqHost[7:0] == CMD_PROGRAM) ? 4 : 0;
			auto = (dqHost[7:0] == CMD_AUTOSEL);
			er = erArm;
			if (erArm) wipe = (aLat[20:12] != PROT_SECTOR);
			busyRd = erArm ? 3 : 0;
			erArm = (dqHost[7:0] == CMD_ERASE);
		end
	end
	always @(negedge (oeN | ceN)) begin
		if (busyRd > 0) begin
			tog = ~tog;
			dq = {8'h00, er ? 1'b0 : ~pv[7], tog, stuck, 2'h0, er & tog, 2'h0};
			busyRd = stuck ? busyRd : busyRd - 1;
			if (busyRd == 0 && !er && pa[20:12] != PROT_SECTOR) mem[pa[3:0]] = pv;
			if (busyRd == 0 && er && wipe) foreach (mem[i]) mem[i] = 16'hFFFF;
		end else if (auto)
			dq = (addr[7:0] == 8'h03) ? 16'h0081 : {15'h0, addr[20:12] == PROT_SECTOR};
		else
			dq = mem[addr[3:0]];
		last = dq;
	end
	// Released bus must not look like valid data
	always @(posedge (oeN | ceN)) dq = ~last;
endmodule : flash_dev_model
`default_nettype wire

// ### test/flash_cmd_and_write_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_and_write_status_tb_top;
	import flash_host_pkg::*;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic        cmdValid = 1'b0;
	logic        stuck = 1'b0;
	logic        busySeen;
	op_t         cmdOp = OP_READ;
	logic [20:0] cmdAddr = '0, flashAddr;
	logic [15:0] cmdData = '0, flashDqOut, flashDqIn, doneData;
	logic        cmdReady, doneValid, doneFail, flashDqOe, flashCeN, flashWeN, flashOeN;
	logic        readyBusyIn, busy, upperBad;
	int          mismatches = 0, nTests = 0, cycles = 0;
	always #25 clk_sys = ~clk_sys;
	flash_host_ctrl #(.POLL_LIMIT(8)) i_dut (.clk_sys(clk_sys), .resetn(resetn), .clkEn(1'b1),
		.cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData),
		.cmdReady(cmdReady), .doneValid(doneValid), .doneFail(doneFail), .doneData(doneData),
		.flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
		.flashDqIn(flashDqIn), .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
		.readyBusyIn(readyBusyIn), .busy(busy));
	flash_dev_model i_flash (.addr(flashAddr), .dqHost(flashDqOut), .ceN(flashCeN),
		.weN(flashWeN), .oeN(flashOeN), .stuck(stuck), .dq(flashDqIn), .rdyBsy(readyBusyIn),
		.upperBad(upperBad));
	// ==========================================
	// Shared tasks
	task automatic print_verdict();
		if (mismatches == 0 && nTests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		nTests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic run(input op_t o, input logic [20:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		cmdOp <= o;
		cmdAddr <= a;
		cmdData <= d;
		cmdValid <= 1'b1;
		@(negedge clk_sys);
		while (cmdReady !== 1'b1) @(negedge clk_sys);
		@(posedge clk_sys);
		cmdValid <= 1'b0;
		busySeen = 1'b0;
		while (doneValid !== 1'b1) begin
			@(negedge clk_sys);
			if (busy === 1'b1) busySeen = 1'b1;
		end
	endtask : run
	// ==========================================
	// Scenarios
	task automatic t_program();
		run(OP_PROGRAM, 21'h000005, 16'h1234);
		check(doneFail, 1'b0);
		check(busySeen, 1'b1);
		run(OP_READ, 21'h000005, 16'h0000);
		check(doneData, 16'h1234);
		check(upperBad, 1'b0);
	endtask : t_program
	task automatic t_timeout();
		stuck = 1'b1;
		run(OP_PROGRAM, 21'h000007, 16'h00AA);
		check(doneFail, 1'b1);
		stuck = 1'b0;
		run(OP_RESET, 21'h000000, 16'h0000);
		run(OP_READ, 21'h000007, 16'h0000);
		check(doneData, 16'h0000);
	endtask : t_timeout
	task automatic t_erase();
		run(OP_SECTOR_ERASE, 21'h003000, 16'h0000);
		check(doneFail, 1'b0);
		run(OP_READ, 21'h000005, 16'h0000);
		check(doneData, 16'hFFFF);
	endtask : t_erase
	task automatic t_autosel();
		logic [20:0] a [3] = '{21'h000003, 21'h1F0002, 21'h003002};
		logic [15:0] e [3] = '{16'h0081, 16'h0001, 16'h0000};
		for (int i = 0; i < 3; i++) begin
			run(OP_AUTOSEL, a[i], 16'h0000);
			check(doneData, e[i]);
			run(OP_RESET, 21'h000000, 16'h0000);
		end
		run(OP_READ, 21'h000009, 16'h0000);
		check(doneData, 16'hFFFF);
	endtask : t_autosel
	task automatic t_refuse();
		run(OP_SUSPEND, 21'h000000, 16'h0000);
		check(doneFail, 1'b1);
		run(OP_RESUME, 21'h000000, 16'h0000);
		check(doneFail, 1'b1);
	endtask : t_refuse
	task automatic t_protect();
		run(OP_PROGRAM, 21'h1F0005, 16'h0000);
		check(doneFail, 1'b1);
		run(OP_PROGRAM, 21'h000006, 16'h5678);
		check(doneFail, 1'b0);
		run(OP_SECTOR_ERASE, 21'h1F0000, 16'h0000);
		check(doneFail, 1'b0);
		run(OP_READ, 21'h000006, 16'h0000);
		check(doneData, 16'h5678);
		run(OP_READ, 21'h000005, 16'h0000);
		check(doneData, 16'hFFFF);
		run(OP_CHIP_ERASE, 21'h000000, 16'h0000);
		check(doneFail, 1'b0);
		run(OP_READ, 21'h000006, 16'h0000);
		check(doneData, 16'hFFFF);
	endtask : t_protect
	// ==========================================
	// Main sequence and hang guard
	initial begin
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		t_program();
		t_timeout();
		t_erase();
		t_autosel();
		t_protect();
		t_refuse();
		print_verdict();
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			print_verdict();
		end
	end
endmodule : flash_cmd_and_write_status_tb_top
`default_nettype wire
